// [hdl/iphc_consts.svh]
// Constants for the idle power command handler: offsets, fields, codes, timing.
// Assumes inclusion by the top module only.
//
// Notes on behaviour
// - Command E3h enters Idle and programs or disables standby timer from sector count.
// - Command E1h enters Idle at once, ignoring any timer value; the code restarts the timer from the last programmed period.
// - Idle command: nonzero sector count enables timer, 00h disables it.
// - 01h-F0h give value*5 s; F1h-FBh give (value-240)*30 min.
// - FCh 21 min, FDh 8 to 12 h, FFh 21 min 15 s; FEh reserved.
// - Good completion: busy clear, ready set, fault, data request, error clear.
// - Without power management support both idle commands abort via aborted bit 2.
// - Aborted bit may be set when the requested idle action cannot complete.
// - Error completion: fault shows device fault, busy and data request clear, ready set.
// - Error completion: status error flag set whenever any error register bit set.
// - Completion interrupt may rise before Idle mode is fully reached.
// - Host picks device with select bit 4; device reflects it at completion.
// - Without packet feature set both idle commands are implemented.
// - With packet feature set the media eject code EDh is not implemented.
// - Unsupported media eject completes as an aborted command.
`ifndef IPHC_CONSTS_SVH
`define IPHC_CONSTS_SVH

// ==========================================================
// Register offsets
`define IPHC_OFF_FEAT_ERR    4'h1
`define IPHC_OFF_SECT_CNT    4'h2
`define IPHC_OFF_ADDR_LOW    4'h3
`define IPHC_OFF_ADDR_MID    4'h4
`define IPHC_OFF_ADDR_HIGH   4'h5
`define IPHC_OFF_DEV_SEL     4'h6
`define IPHC_OFF_CMD_STAT    4'h7
`define IPHC_OFF_IRQ_STAT    4'h8
`define IPHC_OFF_IRQ_MASK    4'h9
`define IPHC_OFF_CONFIG      4'ha
`define IPHC_OFF_POWER       4'hb
`define IPHC_OFF_TIMER_LO    4'hc
`define IPHC_OFF_TIMER_HI    4'hd

// ==========================================================
// Field positions
`define IPHC_ERR_ABORT_BIT   2
`define IPHC_DEV_SEL_BIT     4
`define IPHC_CFG_PM_BIT      0
`define IPHC_CFG_PKT_BIT     1
`define IPHC_IRQ_DONE_BIT    0
`define IPHC_IRQ_STBY_BIT    1
`define IPHC_IRQ_ABORT_BIT   2

// ==========================================================
// Reset values
`define IPHC_CFG_RESET       8'h01
`define IPHC_MASK_RESET      8'h00

// ==========================================================
// Command codes
`define IPHC_CMD_IDLE        8'he3
`define IPHC_CMD_IDLE_NOW    8'he1
`define IPHC_CMD_EJECT       8'hed

// ==========================================================
// Sector count codes and standby periods in 5 s units
`define IPHC_SC_OFF          8'h00
`define IPHC_SC_SEC_MAX      8'hf0
`define IPHC_SC_HALF_H_MAX   8'hfb
`define IPHC_SC_21MIN        8'hfc
`define IPHC_SC_LONG         8'hfd
`define IPHC_SC_RESERVED     8'hfe
`define IPHC_SC_21MIN15      8'hff
`define IPHC_SC_HALF_H_BASE  13'd240
`define IPHC_UNITS_HALF_H    13'd360
`define IPHC_UNITS_21MIN     13'd252
`define IPHC_UNITS_LONG      13'd7200
`define IPHC_UNITS_21MIN15   13'd255

// ==========================================================
// Timing: one timer unit is 5 s
`define IPHC_UNIT_S          5
`define IPHC_CLK_HZ          100000000
`define IPHC_UNIT_CYCLES     (`IPHC_UNIT_S * `IPHC_CLK_HZ)

`endif

// [hdl/iphc_pkg.sv]
// Types shared by the idle power command handler.
// Assumes the constants header sits beside it.
package iphc_pkg;

  // ==========================================================
  // Status byte layout
  typedef struct packed {
    logic busy;
    logic ready;
    logic fault;
    logic rsvd4;
    logic data_request_flag;
    logic rsvd2;
    logic rsvd1;
    logic err;
  } iphc_status_t;

  // ==========================================================
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } iphc_req_t;

  // ==========================================================
  // Command engine and power states
  typedef enum logic [0:0] {
    IPHC_ST_READY,
    IPHC_ST_EXEC
  } iphc_state_t;

  typedef enum logic [0:0] {
    IPHC_PW_IDLE,
    IPHC_PW_STANDBY
  } iphc_power_t;

endpackage

// [hdl/iphc_top.sv]
// Idle power command handler: task-file registers, idle command engine, standby timer.
// Assumes a synchronous register port and a host that waits for busy to clear.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "iphc_consts.svh"

module iphc_top
  import iphc_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `IPHC_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  // Register port
  input  wire iphc_req_t  req_in,
  output logic [7:0]      rdata_out,
  // Device condition
  input  wire logic       dev_fault_in,
  // Power and interrupt
  output logic            standby_out,
  output logic            irq_out
);

  // ==========================================================
  // Standby period decode in 5 s units
  function automatic logic [12:0] period_units(input logic [7:0] sc);
    logic [12:0] units;
    units = 13'h0000;
    if (sc <= `IPHC_SC_SEC_MAX) begin
      units = {5'h00, sc};
    end else if (sc <= `IPHC_SC_HALF_H_MAX) begin
      units = 13'(({5'h00, sc} - `IPHC_SC_HALF_H_BASE) * `IPHC_UNITS_HALF_H);
    end else if (sc == `IPHC_SC_21MIN) begin
      units = `IPHC_UNITS_21MIN;
    end else if (sc == `IPHC_SC_LONG) begin
      units = `IPHC_UNITS_LONG;
    end else if (sc == `IPHC_SC_21MIN15) begin
      units = `IPHC_UNITS_21MIN15;
    end
    return units;
  endfunction

  // ==========================================================
  // Registers
  logic [7:0]  features_q;
  logic [7:0]  sector_count_q;
  logic [7:0]  block_addr_low_q;
  logic [7:0]  block_addr_mid_q;
  logic [7:0]  block_addr_high_q;
  logic [7:0]  device_select_q;
  logic [7:0]  command_q;
  logic [7:0]  error_q,     error_d;
  iphc_status_t status_q,   status_d;
  logic [7:0]  irq_stat_q,  irq_stat_d;
  logic [7:0]  irq_mask_q;
  logic [7:0]  config_q;
  iphc_state_t state_q,     state_d;
  iphc_power_t power_q,     power_d;
  logic        tmr_en_q,    tmr_en_d;
  logic [12:0] tmr_units_q, tmr_units_d;
  logic [12:0] tmr_left_q,  tmr_left_d;
  logic [31:0] div_q;
  logic [7:0]  rdata_q;
  logic        irq_q;
  logic        standby_q;

  // ==========================================================
  // Address decode
  wire is_wr       = req_in.wr;
  wire is_rd       = req_in.rd;
  wire hit_feat    = req_in.addr == `IPHC_OFF_FEAT_ERR;
  wire hit_sc      = req_in.addr == `IPHC_OFF_SECT_CNT;
  wire hit_low     = req_in.addr == `IPHC_OFF_ADDR_LOW;
  wire hit_mid     = req_in.addr == `IPHC_OFF_ADDR_MID;
  wire hit_high    = req_in.addr == `IPHC_OFF_ADDR_HIGH;
  wire hit_dev     = req_in.addr == `IPHC_OFF_DEV_SEL;
  wire hit_cmd     = req_in.addr == `IPHC_OFF_CMD_STAT;
  wire hit_istat   = req_in.addr == `IPHC_OFF_IRQ_STAT;
  wire hit_imask   = req_in.addr == `IPHC_OFF_IRQ_MASK;
  wire hit_cfg     = req_in.addr == `IPHC_OFF_CONFIG;
  // Task-file writes are ignored while busy
  wire tf_wr_ok    = is_wr && (state_q == IPHC_ST_READY);
  wire cmd_wr      = tf_wr_ok && hit_cmd;

  // ==========================================================
  // Command classification
  wire pkt_set     = config_q[`IPHC_CFG_PKT_BIT];
  wire pm_support  = config_q[`IPHC_CFG_PM_BIT] || !pkt_set;
  wire is_idle     = command_q == `IPHC_CMD_IDLE;
  wire is_idle_now = command_q == `IPHC_CMD_IDLE_NOW;
  wire is_eject    = command_q == `IPHC_CMD_EJECT;
  wire sc_reserved = sector_count_q == `IPHC_SC_RESERVED;
  // Reserved period cannot be honoured, so the idle command aborts
  wire idle_fail   = is_idle && sc_reserved;
  wire idle_ok     = (is_idle || is_idle_now) && pm_support && !idle_fail;
  // No eject mechanism: eject always aborts, also with packet set
  wire eject_abort = is_eject;
  wire do_abort    = !idle_ok || eject_abort;
  wire exec        = state_q == IPHC_ST_EXEC;

  // ==========================================================
  // Timer tick divider, one pulse per 5 s
  wire tick        = div_q == 32'(UNIT_CYCLES - 1);
  wire tmr_expire  = tmr_en_q && tick && (tmr_left_q == 13'h0001) &&
                     (power_q == IPHC_PW_IDLE);

  // ==========================================================
  // Command engine next state
  always_comb begin
    state_d  = state_q;
    error_d  = error_q;
    status_d = status_q;
    if (cmd_wr) begin
      state_d         = IPHC_ST_EXEC;
      status_d.busy   = 1'b1;
      status_d.data_request_flag    = 1'b0;
    end else if (exec) begin
      state_d         = IPHC_ST_READY;
      error_d         = 8'h00;
      error_d[`IPHC_ERR_ABORT_BIT] = do_abort;
      status_d.busy   = 1'b0;
      status_d.ready  = 1'b1;
      status_d.data_request_flag    = 1'b0;
      status_d.fault  = do_abort && dev_fault_in;
      status_d.err    = do_abort;
    end
  end

  // ==========================================================
  // Power mode and standby timer next state
  always_comb begin
    power_d     = power_q;
    tmr_en_d    = tmr_en_q;
    tmr_units_d = tmr_units_q;
    tmr_left_d  = tmr_left_q;
    if (exec && idle_ok && !eject_abort) begin
      power_d = IPHC_PW_IDLE;
      if (is_idle) begin
        tmr_en_d    = sector_count_q != `IPHC_SC_OFF;
        tmr_units_d = period_units(sector_count_q);
        tmr_left_d  = period_units(sector_count_q);
      end else begin
        tmr_left_d  = tmr_units_q;
      end
    end else if (tmr_expire) begin
      power_d    = IPHC_PW_STANDBY;
      tmr_left_d = 13'h0000;
    end else if (tmr_en_q && tick && (tmr_left_q != 13'h0000)) begin
      tmr_left_d = tmr_left_q - 13'h0001;
    end
  end

  // ==========================================================
  // Interrupt status: set wins over write-one clear
  wire [7:0] irq_set = {5'h00,
                        exec && do_abort,
                        tmr_expire,
                        exec};
  wire [7:0] irq_clr = (is_wr && hit_istat) ? req_in.wdata : 8'h00;
  assign irq_stat_d  = (irq_stat_q & ~irq_clr) | irq_set;

  // ==========================================================
  // Read mux
  wire [7:0] rd_mux =
      hit_feat  ? error_q :
      hit_sc    ? sector_count_q :
      hit_low   ? block_addr_low_q :
      hit_mid   ? block_addr_mid_q :
      hit_high  ? block_addr_high_q :
      hit_dev   ? device_select_q :
      hit_cmd   ? status_q :
      hit_istat ? irq_stat_q :
      hit_imask ? irq_mask_q :
      hit_cfg   ? config_q :
      (req_in.addr == `IPHC_OFF_POWER)    ? {6'h00, tmr_en_q, power_q == IPHC_PW_STANDBY} :
      (req_in.addr == `IPHC_OFF_TIMER_LO) ? tmr_left_q[7:0] :
      (req_in.addr == `IPHC_OFF_TIMER_HI) ? {3'h0, tmr_left_q[12:8]} :
      8'h00;

  // ==========================================================
  // Task-file registers
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      features_q        <= 8'h00;
      sector_count_q    <= 8'h00;
      block_addr_low_q  <= 8'h00;
      block_addr_mid_q  <= 8'h00;
      block_addr_high_q <= 8'h00;
      device_select_q   <= 8'h00;
      command_q         <= 8'h00;
    end else if (tf_wr_ok) begin
      if (hit_feat)  features_q        <= req_in.wdata;
      if (hit_sc)    sector_count_q    <= req_in.wdata;
      if (hit_low)   block_addr_low_q  <= req_in.wdata;
      if (hit_mid)   block_addr_mid_q  <= req_in.wdata;
      if (hit_high)  block_addr_high_q <= req_in.wdata;
      if (hit_dev)   device_select_q   <= req_in.wdata;
      if (hit_cmd)   command_q         <= req_in.wdata;
    end
  end

  // ==========================================================
  // Control registers written by software
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      irq_mask_q <= `IPHC_MASK_RESET;
      config_q   <= `IPHC_CFG_RESET;
    end else if (is_wr) begin
      if (hit_imask) irq_mask_q <= req_in.wdata;
      if (hit_cfg)   config_q   <= {6'h00, req_in.wdata[1:0]};
    end
  end

  // ==========================================================
  // Engine, timer and interrupt state
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_q     <= IPHC_ST_READY;
      error_q     <= 8'h00;
      status_q    <= 8'h40;
      power_q     <= IPHC_PW_IDLE;
      tmr_en_q    <= 1'b0;
      tmr_units_q <= 13'h0000;
      tmr_left_q  <= 13'h0000;
      irq_stat_q  <= 8'h00;
    end else begin
      state_q     <= state_d;
      error_q     <= error_d;
      status_q    <= status_d;
      power_q     <= power_d;
      tmr_en_q    <= tmr_en_d;
      tmr_units_q <= tmr_units_d;
      tmr_left_q  <= tmr_left_d;
      irq_stat_q  <= irq_stat_d;
    end
  end

  // ==========================================================
  // Tick divider, restarted by each accepted command
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || tick || cmd_wr) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rdata_q   <= 8'h00;
      irq_q     <= 1'b0;
      standby_q <= 1'b0;
    end else begin
      rdata_q   <= is_rd ? rd_mux : 8'h00;
      irq_q     <= |(irq_stat_d & irq_mask_q);
      standby_q <= power_d == IPHC_PW_STANDBY;
    end
  end

  assign rdata_out   = rdata_q;
  assign irq_out     = irq_q;
  assign standby_out = standby_q;

endmodule // iphc_top

// [verif/iphc_chk.sv]
// Port-level checker for the idle power command handler.
// Assumes binding onto the top module and a host that never writes while busy.
`timescale 1ns/1ps

module iphc_chk
  import iphc_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = 10
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  // Register port
  input  wire iphc_req_t  req_in,
  input  wire logic [7:0] rdata_out,
  // Device condition, power and interrupt
  input  wire logic       dev_fault_in,
  input  wire logic       standby_out,
  input  wire logic       irq_out
);
  // ==========================================================
  // Decoded strobes
  wire logic cmd_wr = req_in.wr && req_in.addr == 4'h7;
  wire logic st_rd  = req_in.rd && req_in.addr == 4'h7;

  // Cycles since the last command write, saturating
  logic [15:0] since_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || cmd_wr) since_q <= 16'h0000;
    else if (since_q != 16'hffff) since_q <= since_q + 16'h0001;
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // ==========================================================
  // Register port and status
  a_rd_quiet: assert property (!req_in.rd |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_status_flags: assert property (st_rd |=> rdata_out[6] && !rdata_out[3])
    else $error("status ready or data request wrong");
  a_done_in_two: assert property ($past(cmd_wr, 2) && st_rd |=> !rdata_out[7])
    else $error("busy still set two cycles after command");
  a_fault_shown: assert property ($past(cmd_wr, 2) && $past(req_in.wdata, 2) == 8'h20
    && $past(dev_fault_in) && st_rd |=> rdata_out[5] && rdata_out[0])
    else $error("fault not shown in aborted status");
  a_dev_echo: assert property ((req_in.wr && req_in.addr == 4'h6) ##2
    (req_in.rd && req_in.addr == 4'h6) |=> rdata_out == $past(req_in.wdata, 3))
    else $error("device select not read back");

  // ==========================================================
  // Interrupt and standby
  a_mask_drops: assert property (req_in.wr && req_in.addr == 4'h9
    && req_in.wdata == 8'h00 |-> ##2 !irq_out)
    else $error("interrupt stays up after masking");
  a_clear_drops: assert property (req_in.wr && req_in.addr == 4'h8
    && req_in.wdata == 8'hff |-> ##2 !irq_out)
    else $error("interrupt stays up after clear");
  a_standby_exit: assert property ($fell(standby_out) |->
    $past(cmd_wr, 2) || $past(cmd_wr, 3) || $past(cmd_wr, 4))
    else $error("standby left without a command");
  a_standby_early: assert property ($rose(standby_out) |-> since_q >= UNIT_CYCLES - 1)
    else $error("standby entered too soon after command");
endmodule // iphc_chk

// [verif/iphc_host.sv]
// Host adapter model driving the register port of the idle command handler.
// Assumes one shared clock and a single caller at a time.
`timescale 1ns/1ps

module iphc_host
  import iphc_pkg::*;
(
  // Clock
  input  wire logic       clk_in,
  // Register port
  output iphc_req_t       req_out,
  input  wire logic [7:0] rdata_in
);
  // ==========================================================
  // Bus cycles; released lines show inverted values
  int hangs = 0;
  initial req_out = '0;

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    req_out <= '{~a, ~d, 1'b0, 1'b0};
  endtask

  // Read data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in);
    req_out <= '{~a, 8'hff, 1'b0, 1'b0};
    @(negedge clk_in);
    d = rdata_in;
  endtask

  // Polls status up to 8 times for ready and not busy, then issues the command
  task automatic cmd(input logic [7:0] c);
    logic [7:0] s;
    int         n;
    n = 0;
    s = 8'h80;
    while ((s[7] || !s[6]) && n < 8) begin
      rd(4'h7, s);
      n++;
    end
    if (s[7] || !s[6]) hangs++;
    wr(4'h7, c);
  endtask
endmodule // iphc_host

// [verif/iphc_tb_top.sv]
// Bench for the idle power command handler: a table of commands, then hand cases.
// Assumes the host model owns the register port and the checker is bound below.
`timescale 1ns/1ps

module iphc_tb_top
  import iphc_pkg::*;
;
  // ==========================================================
  // Signals and case table
  typedef struct packed {
    logic [7:0]  sc;
    logic [7:0]  op;
    logic [7:0]  err;
    logic [7:0]  stat;
    logic [15:0] units;
  } iphc_row_t;

  localparam int unsigned UNITS = 10;
  logic       clk;
  logic       resetn;
  logic       fault;
  iphc_req_t  req;
  logic [7:0] rdata, v, lo, hi;
  logic       standby, irq;
  int         miscompares = 0;
  int         num_checks = 0;
  int         n;
  logic [3:0] rst_addr [5] = '{4'h7, 4'h1, 4'ha, 4'h9, 4'h8};
  logic [7:0] rst_val [5] = '{8'h40, 8'h00, 8'h01, 8'h00, 8'h00};
  iphc_row_t  rows [12] = '{
    '{8'h05, 8'he3, 8'h00, 8'h40, 16'h0005},
    '{8'h00, 8'he3, 8'h00, 8'h40, 16'h0000},
    '{8'hf0, 8'he3, 8'h00, 8'h40, 16'h00f0},
    '{8'hf1, 8'he3, 8'h00, 8'h40, 16'h0168},
    '{8'hfb, 8'he3, 8'h00, 8'h40, 16'h0f78},
    '{8'hfc, 8'he3, 8'h00, 8'h40, 16'h00fc},
    '{8'hfd, 8'he3, 8'h00, 8'h40, 16'h1c20},
    '{8'h00, 8'he1, 8'h00, 8'h40, 16'h1c20},
    '{8'hff, 8'he3, 8'h00, 8'h40, 16'h00ff},
    '{8'hfe, 8'he3, 8'h04, 8'h41, 16'hffff},
    '{8'h00, 8'hed, 8'h04, 8'h41, 16'hffff},
    '{8'h00, 8'h20, 8'h04, 8'h41, 16'hffff}
  };

  // Free-running 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  iphc_top #(.UNIT_CYCLES(UNITS)) u_iphc_top (
    .core_clk_in (clk),
    .resetn_in   (resetn),
    .req_in      (req),
    .rdata_out   (rdata),
    .dev_fault_in(fault),
    .standby_out (standby),
    .irq_out     (irq)
  );
  iphc_host u_iphc_host (.clk_in(clk), .req_out(req), .rdata_in(rdata));

  // ==========================================================
  // Compare, verdict and watchdog
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    fault  = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      u_iphc_host.wr(4'h2, rows[i].sc);
      u_iphc_host.cmd(rows[i].op);
      u_iphc_host.rd(4'hc, lo);
      u_iphc_host.rd(4'hd, hi);
      u_iphc_host.rd(4'h1, v);
      check(v, rows[i].err);
      u_iphc_host.rd(4'h7, v);
      check(v, rows[i].stat);
      if (rows[i].units != 16'hffff) check({hi, lo}, rows[i].units);
    end
    $display("test table done");
    u_iphc_host.wr(4'h6, 8'h10);
    u_iphc_host.rd(4'h6, v);
    check(v, 8'h10);
    u_iphc_host.cmd(8'he1);
    u_iphc_host.rd(4'h6, v);
    check(v, 8'h10);
    $display("test select done");
    u_iphc_host.wr(4'h9, 8'h01);
    u_iphc_host.cmd(8'he1);
    u_iphc_host.rd(4'h8, v);
    check({v[0], irq}, 2'b11);
    u_iphc_host.wr(4'h8, 8'hff);
    u_iphc_host.wr(4'h9, 8'h00);
    u_iphc_host.cmd(8'he1);
    u_iphc_host.rd(4'h8, v);
    check({v[0], irq}, 2'b10);
    u_iphc_host.wr(4'h8, 8'hff);
    $display("test interrupt done");
    @(posedge clk) fault <= 1'b1;
    u_iphc_host.cmd(8'h20);
    u_iphc_host.rd(4'h7, v);
    check(v, 8'h61);
    @(posedge clk) fault <= 1'b0;
    u_iphc_host.cmd(8'he1);
    u_iphc_host.rd(4'h7, v);
    check(v, 8'h40);
    for (int k = 0; k < 4; k++) begin
      u_iphc_host.wr(4'ha, k[1] ? 8'h00 : 8'h02);
      u_iphc_host.cmd(k[0] ? 8'he1 : 8'he3);
      u_iphc_host.rd(4'h1, v);
      check(v, k[1] ? 8'h00 : 8'h04);
    end
    u_iphc_host.wr(4'ha, 8'h01);
    u_iphc_host.rd(4'hf, v);
    check(v, 8'h00);
    $display("test abort done");
    u_iphc_host.wr(4'h2, 8'h01);
    u_iphc_host.cmd(8'he3);
    n = 0;
    while (!standby && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      miscompares++;
      report_and_stop();
    end
    check(n > 7 && n < 16, 1'b1);
    u_iphc_host.rd(4'h8, v);
    check(v[1], 1'b1);
    u_iphc_host.cmd(8'he1);
    u_iphc_host.rd(4'h7, v);
    u_iphc_host.rd(4'hb, v);
    check({v[0], standby}, 2'b00);
    $display("test standby done");
    u_iphc_host.wr(4'h9, 8'h05);
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    foreach (rst_addr[i]) begin
      u_iphc_host.rd(rst_addr[i], v);
      check(v, rst_val[i]);
    end
    check({standby, irq}, 2'b00);
    check(u_iphc_host.hangs, 16'h0000);
    $display("test reset done");
    report_and_stop();
  end
endmodule // iphc_tb_top

bind iphc_top iphc_chk #(.UNIT_CYCLES(UNIT_CYCLES)) u_iphc_chk (
  .core_clk_in (core_clk_in),
  .resetn_in   (resetn_in),
  .req_in      (req_in),
  .rdata_out   (rdata_out),
  .dev_fault_in(dev_fault_in),
  .standby_out (standby_out),
  .irq_out     (irq_out)
);
